/* File: hdl/ddrcap_top.v */
// Transmit capture for channel pairs C/D, E/F and G/H
// Assumes pins, link clocks and mode straps arrive asynchronous to ref_clk_i
//
// Function
// - Each pair bus is taken on both edges of its chosen transmit clock.
// - Word bit 0 is the first bit the serializer sends.
// - The C/D bus uses its own clock in independent mode, else the shared clock.
// - The E/F bus uses its own clock in independent mode, else the shared clock.
// - The G/H bus uses its own clock in independent mode, else the shared clock.
// - In multiplexed mode without encoding line 8 is the ninth word bit.
// - In multiplexed mode without encoding line 9 is the tenth word bit.
// - In multiplexed mode with encoding line 8 marks the byte as a K-character.
// - In nibble mode the low nibble comes on the falling edge, the high on the next rise.
// - In nibble mode the lower channel uses lines 4:0 and the higher lines 9:5.
// - In nibble mode without encoding line 9 carries bits four and nine of the higher word.
// - In nibble mode with encoding line 8 and line 3 are the K flags of high and low.
`timescale 1ns/1ps
`include "ddrcap_regs.vh"
module ddrcap_top (
  input  wire                      ref_clk_i,
  input  wire                      nrst_i,
  input  wire                      tx_clk_shared_i,
  input  wire                      tx_clk_pair_cd_i,
  input  wire                      tx_clk_pair_ef_i,
  input  wire                      tx_clk_pair_gh_i,
  input  wire [`DDRCAP_WORD_W-1:0] tx_bus_pair_cd_i,
  input  wire [`DDRCAP_WORD_W-1:0] tx_bus_pair_ef_i,
  input  wire [`DDRCAP_WORD_W-1:0] tx_bus_pair_gh_i,
  input  wire                      mode_independent_i,
  input  wire                      mode_nibble_i,
  input  wire                      encoder_sel_i,
  output wire [`DDRCAP_WORD_W-1:0] chan_c_word_o,
  output wire                      chan_c_k_o,
  output wire                      chan_c_valid_o,
  output wire [`DDRCAP_WORD_W-1:0] chan_d_word_o,
  output wire                      chan_d_k_o,
  output wire                      chan_d_valid_o,
  output wire [`DDRCAP_WORD_W-1:0] chan_e_word_o,
  output wire                      chan_e_k_o,
  output wire                      chan_e_valid_o,
  output wire [`DDRCAP_WORD_W-1:0] chan_f_word_o,
  output wire                      chan_f_k_o,
  output wire                      chan_f_valid_o,
  output wire [`DDRCAP_WORD_W-1:0] chan_g_word_o,
  output wire                      chan_g_k_o,
  output wire                      chan_g_valid_o,
  output wire [`DDRCAP_WORD_W-1:0] chan_h_word_o,
  output wire                      chan_h_k_o,
  output wire                      chan_h_valid_o,
  output wire [2:0]                orphan_o,
  output wire [2:0]                line9_warn_o,
  output reg  [2:0]                clk_active_o,
  output reg  [2:0]                cfg_o
);
  wire [`DDRCAP_SYNC_CLK_W-1:0] clk_stable;
  wire [`DDRCAP_SYNC_BUS_W-1:0] bus_stable;
  wire [`DDRCAP_SYNC_CFG_W-1:0] cfg_stable;
  reg  [`DDRCAP_SYNC_CLK_W-1:0] clk_prev;
  wire [`DDRCAP_SYNC_CLK_W-1:0] clk_rise;
  wire [`DDRCAP_SYNC_CLK_W-1:0] clk_fall;
  wire [2:0]                    sel_rise;
  wire [2:0]                    sel_fall;
  wire [`DDRCAP_SYNC_BUS_W-1:0] lo_word;
  wire [`DDRCAP_SYNC_BUS_W-1:0] hi_word;
  wire [2:0]                    lo_k;
  wire [2:0]                    hi_k;
  wire [2:0]                    lo_valid;
  wire [2:0]                    hi_valid;
  reg  [`DDRCAP_IDLE_W-1:0]     idle_cnt [0:2];
  wire                          ind_mode;
  reg  [`DDRCAP_ARM_W-1:0]      arm_sr;
  wire                          armed;

  // Link clocks, shared first, then C/D, E/F, G/H
  ddrcap_sync #(
    .W (`DDRCAP_SYNC_CLK_W)
  ) u_sync_clk (
    .clk_i    (ref_clk_i),
    .nrst_i   (nrst_i),
    .d_i      ({tx_clk_pair_gh_i, tx_clk_pair_ef_i, tx_clk_pair_cd_i, tx_clk_shared_i}),
    .stable_o (clk_stable)
  );

  // Buses pass the same depth so data stays aligned to its edges
  ddrcap_sync #(
    .W (`DDRCAP_SYNC_BUS_W)
  ) u_sync_bus (
    .clk_i    (ref_clk_i),
    .nrst_i   (nrst_i),
    .d_i      ({tx_bus_pair_gh_i, tx_bus_pair_ef_i, tx_bus_pair_cd_i}),
    .stable_o (bus_stable)
  );

  // Mode straps
  ddrcap_sync #(
    .W (`DDRCAP_SYNC_CFG_W)
  ) u_sync_cfg (
    .clk_i    (ref_clk_i),
    .nrst_i   (nrst_i),
    .d_i      ({encoder_sel_i, mode_nibble_i, mode_independent_i}),
    .stable_o (cfg_stable)
  );

  assign ind_mode = cfg_stable[`DDRCAP_CFG_IND];

  // Edge detection on filtered clock levels
  // Edges masked until the synchroniser holds real pin levels, so a pulled-up pin gives no edge
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_prev <= 4'h0;
      arm_sr   <= 5'h00;
    end else begin
      clk_prev <= clk_stable;
      arm_sr   <= {arm_sr[`DDRCAP_ARM_W-2:0], 1'b1};
    end
  end

  assign armed = arm_sr[`DDRCAP_ARM_W-1];

  assign clk_rise = clk_stable & ~clk_prev & {`DDRCAP_SYNC_CLK_W{armed}};
  assign clk_fall = ~clk_stable & clk_prev & {`DDRCAP_SYNC_CLK_W{armed}};

  genvar p;
  generate
    for (p = 0; p < `DDRCAP_NUM_PAIRS; p = p + 1) begin : g_pair
      assign sel_rise[p] = ind_mode ? clk_rise[p+1] : clk_rise[`DDRCAP_CLK_SHARED];
      assign sel_fall[p] = ind_mode ? clk_fall[p+1] : clk_fall[`DDRCAP_CLK_SHARED];

      ddrcap_pair u_pair (
        .clk_i        (ref_clk_i),
        .nrst_i       (nrst_i),
        .rise_i       (sel_rise[p]),
        .fall_i       (sel_fall[p]),
        .bus_i        (bus_stable[p*10 +: 10]),
        .nibble_i     (cfg_stable[`DDRCAP_CFG_NIB]),
        .code_i       (cfg_stable[`DDRCAP_CFG_CODE]),
        .lo_word_o    (lo_word[p*10 +: 10]),
        .lo_k_o       (lo_k[p]),
        .lo_valid_o   (lo_valid[p]),
        .hi_word_o    (hi_word[p*10 +: 10]),
        .hi_k_o       (hi_k[p]),
        .hi_valid_o   (hi_valid[p]),
        .orphan_o     (orphan_o[p]),
        .line9_warn_o (line9_warn_o[p])
      );

      // Selected clock watchdog
      always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          idle_cnt[p]     <= 8'h00;
          clk_active_o[p] <= 1'b0;
        end else begin
          if (sel_rise[p] | sel_fall[p]) begin
            idle_cnt[p]     <= 8'h00;
            clk_active_o[p] <= 1'b1;
          end else if (idle_cnt[p] < `DDRCAP_IDLE_CYC) begin
            idle_cnt[p] <= idle_cnt[p] + 8'h01;
          end else begin
            clk_active_o[p] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Mode as seen by the capture logic
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_o <= 3'h0;
    end else begin
      cfg_o <= cfg_stable;
    end
  end

  assign chan_c_word_o  = lo_word[9:0];
  assign chan_c_k_o     = lo_k[0];
  assign chan_c_valid_o = lo_valid[0];
  assign chan_d_word_o  = hi_word[9:0];
  assign chan_d_k_o     = hi_k[0];
  assign chan_d_valid_o = hi_valid[0];
  assign chan_e_word_o  = lo_word[19:10];
  assign chan_e_k_o     = lo_k[1];
  assign chan_e_valid_o = lo_valid[1];
  assign chan_f_word_o  = hi_word[19:10];
  assign chan_f_k_o     = hi_k[1];
  assign chan_f_valid_o = hi_valid[1];
  assign chan_g_word_o  = lo_word[29:20];
  assign chan_g_k_o     = lo_k[2];
  assign chan_g_valid_o = lo_valid[2];
  assign chan_h_word_o  = hi_word[29:20];
  assign chan_h_k_o     = hi_k[2];
  assign chan_h_valid_o = hi_valid[2];
endmodule // ddrcap_top

/* File: hdl/ddrcap_regs.vh */
// Constants for the double-data-rate transmit capture block
// Assumes a 250 MHz sampling clock and link clocks well below it
`ifndef DDRCAP_REGS_VH
`define DDRCAP_REGS_VH

`define DDRCAP_WORD_W      10
`define DDRCAP_HALF_W      5
`define DDRCAP_NUM_PAIRS   3
`define DDRCAP_SYNC_CLK_W  4
`define DDRCAP_SYNC_BUS_W  30
`define DDRCAP_SYNC_CFG_W  3

`define DDRCAP_BIT_KFLAG   8
`define DDRCAP_BIT_TENTH   9
`define DDRCAP_NIB_KFLAG   3

`define DDRCAP_CFG_IND     0
`define DDRCAP_CFG_NIB     1
`define DDRCAP_CFG_CODE    2

`define DDRCAP_CLK_SHARED  0

`define DDRCAP_REF_NS      4
`define DDRCAP_IDLE_NS     256
`define DDRCAP_IDLE_CYC    (`DDRCAP_IDLE_NS / `DDRCAP_REF_NS)
`define DDRCAP_IDLE_W      8
`define DDRCAP_ARM_W       5

`endif

/* File: hdl/ddrcap_sync.v */
// Three-stage pin synchroniser with agreement filter
// Assumes inputs asynchronous to clk_i; stable_o moves when stages two and three agree
`timescale 1ns/1ps
module ddrcap_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         nrst_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] stable_o
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1       <= {W{1'b0}};
      s2       <= {W{1'b0}};
      s3       <= {W{1'b0}};
      stable_o <= {W{1'b0}};
    end else begin
      s1       <= d_i;
      s2       <= s1;
      s3       <= s2;
      stable_o <= (s2 & ~(s2 ^ s3)) | (stable_o & (s2 ^ s3));
    end
  end
endmodule // ddrcap_sync

/* File: hdl/ddrcap_pair.v */
// Capture of one channel pair bus on both link clock edges
// Assumes one-cycle edge pulses and a bus already aligned to them
`timescale 1ns/1ps
`include "ddrcap_regs.vh"
module ddrcap_pair (
  input  wire                      clk_i,
  input  wire                      nrst_i,
  input  wire                      rise_i,
  input  wire                      fall_i,
  input  wire [`DDRCAP_WORD_W-1:0] bus_i,
  input  wire                      nibble_i,
  input  wire                      code_i,
  output reg  [`DDRCAP_WORD_W-1:0] lo_word_o,
  output reg                       lo_k_o,
  output reg                       lo_valid_o,
  output reg  [`DDRCAP_WORD_W-1:0] hi_word_o,
  output reg                       hi_k_o,
  output reg                       hi_valid_o,
  output reg                       orphan_o,
  output reg                       line9_warn_o
);
  reg [`DDRCAP_WORD_W-1:0] fall_half;
  reg                      have_fall;

  // Joins two five-line halves; bit 0 stays at word bit 0, sent first
  function [`DDRCAP_WORD_W-1:0] nib_word;
    input [`DDRCAP_HALF_W-1:0] f;
    input [`DDRCAP_HALF_W-1:0] r;
    input                      code;
    begin
      if (code) begin
        nib_word = {2'b00, r[4], r[2:0], f[4], f[2:0]};
      end else begin
        nib_word = {r, f};
      end
    end
  endfunction

  // Direct word: eight data bits when encoding, else all ten lines
  function [`DDRCAP_WORD_W-1:0] mux_word;
    input [`DDRCAP_WORD_W-1:0] b;
    input                      code;
    begin
      if (code) begin
        mux_word = {2'b00, b[7:0]};
      end else begin
        mux_word = b;
      end
    end
  endfunction

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lo_word_o    <= 10'h000;
      lo_k_o       <= 1'b0;
      lo_valid_o   <= 1'b0;
      hi_word_o    <= 10'h000;
      hi_k_o       <= 1'b0;
      hi_valid_o   <= 1'b0;
      orphan_o     <= 1'b0;
      line9_warn_o <= 1'b0;
      fall_half    <= 10'h000;
      have_fall    <= 1'b0;
    end else begin
      lo_valid_o   <= 1'b0;
      hi_valid_o   <= 1'b0;
      orphan_o     <= 1'b0;
      line9_warn_o <= code_i & ~nibble_i & (rise_i | fall_i) & bus_i[`DDRCAP_BIT_TENTH];
      if (nibble_i) begin
        if (fall_i) begin
          fall_half <= bus_i;
          have_fall <= 1'b1;
        end else if (rise_i) begin
          have_fall <= 1'b0;
          if (have_fall) begin
            lo_word_o  <= nib_word(fall_half[4:0], bus_i[4:0], code_i);
            hi_word_o  <= nib_word(fall_half[9:5], bus_i[9:5], code_i);
            lo_k_o     <= code_i & bus_i[`DDRCAP_NIB_KFLAG];
            hi_k_o     <= code_i & bus_i[`DDRCAP_BIT_KFLAG];
            lo_valid_o <= 1'b1;
            hi_valid_o <= 1'b1;
          end else begin
            orphan_o <= 1'b1;
          end
        end
      end else begin
        have_fall <= 1'b0;
        if (rise_i) begin
          hi_word_o  <= mux_word(bus_i, code_i);
          hi_k_o     <= code_i & bus_i[`DDRCAP_BIT_KFLAG];
          hi_valid_o <= 1'b1;
        end
        if (fall_i) begin
          lo_word_o  <= mux_word(bus_i, code_i);
          lo_k_o     <= code_i & bus_i[`DDRCAP_BIT_KFLAG];
          lo_valid_o <= 1'b1;
        end
      end
    end
  end
endmodule // ddrcap_pair

/* File: verification/ddrcap_monitor.sv */
// Checker for the transmit capture top level
// Assumes it is bound to ddrcap_top and sees its ports only
`timescale 1ns/1ps
`include "ddrcap_regs.vh"
module ddrcap_monitor (
  input wire                      ref_clk_i,
  input wire                      nrst_i,
  input wire                      tx_clk_shared_i,
  input wire [`DDRCAP_WORD_W-1:0] chan_c_word_o,
  input wire                      chan_c_valid_o,
  input wire [`DDRCAP_WORD_W-1:0] chan_d_word_o,
  input wire                      chan_d_k_o,
  input wire                      chan_d_valid_o,
  input wire [2:0]                orphan_o,
  input wire [2:0]                line9_warn_o,
  input wire [2:0]                cfg_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence shr_quiet;
    $stable(tx_clk_shared_i) [*8];
  endsequence
  sequence nib_emit;
    cfg_o[1] && chan_d_valid_o;
  endsequence
  a_valid_single_c: assert property (chan_c_valid_o |=> !chan_c_valid_o)
    else $error("c valid longer than one cycle");
  a_word_hold_d: assert property (!chan_d_valid_o |-> $stable(chan_d_word_o))
    else $error("d word moved without valid");
  a_shared_quiet: assert property (shr_quiet |-> cfg_o[0] || !chan_d_valid_o)
    else $error("d word without shared clock edge");
  a_nib_both_emit: assert property (nib_emit |-> chan_c_valid_o)
    else $error("nibble words not emitted together");
  a_code_upper_zero: assert property (cfg_o[2] && chan_c_valid_o |-> chan_c_word_o[9:8] == 2'b00)
    else $error("encoded word upper bits set");
  a_plain_no_k: assert property (!cfg_o[2] && chan_d_valid_o |-> !chan_d_k_o)
    else $error("k flag without encoder");
  a_warn_encode_only: assert property (line9_warn_o[0] |-> cfg_o[2] && !cfg_o[1])
    else $error("line nine warning outside encoded multiplexed mode");
  a_orphan_nibble_only: assert property (orphan_o[0] |-> cfg_o[1] && !chan_c_valid_o)
    else $error("orphan outside nibble mode or with a word");
endmodule // ddrcap_monitor
bind ddrcap_top ddrcap_monitor i_mon (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .tx_clk_shared_i(tx_clk_shared_i), .chan_c_word_o(chan_c_word_o),
  .chan_c_valid_o(chan_c_valid_o), .chan_d_word_o(chan_d_word_o), .chan_d_k_o(chan_d_k_o),
  .chan_d_valid_o(chan_d_valid_o), .orphan_o(orphan_o), .line9_warn_o(line9_warn_o),
  .cfg_o(cfg_o));

/* File: verification/ddrcap_src.sv */
// Model of the protocol device driving the pair buses and link clocks
// Assumes the bench calls drive_edge; clocks stand still between calls
`timescale 1ns/1ps
module ddrcap_src (
  output logic [3:0]  clk_o,
  output logic [29:0] bus_o
);
  initial begin
    clk_o = 4'h0;
    bus_o = 30'h0000_0000;
  end
  task automatic drive_edge(input logic [3:0] m, input logic l, input logic [29:0] d);
    bus_o <= d;
    #8;
    clk_o <= l ? (clk_o | m) : (clk_o & ~m);
    #8;
  endtask
  // Line nine pulled low, other lines show the inverse
  task automatic release_bus();
    bus_o <= ~bus_o & ~30'h2008_0200;
  endtask
endmodule // ddrcap_src

/* File: verification/tb_top.sv */
// Self-checking bench for the transmit capture block
// Assumes the source model drives link side; checker is bound to the top
`timescale 1ns/1ps
`include "ddrcap_regs.vh"
module tb_top;
  logic        ref_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        m_ind     = 1'b0;
  logic        m_nib     = 1'b0;
  logic        m_code    = 1'b0;
  wire  [3:0]  clks;
  wire  [29:0] bus;
  wire  [59:0] word;
  wire  [5:0]  kf;
  wire  [5:0]  vld;
  wire  [2:0]  orph;
  wire  [2:0]  warn;
  wire  [2:0]  cfg;
  wire  [2:0]  act;
  logic [10:0] got[6][$];
  int          errors   = 0;
  int          n_checks = 0;
  int          cyc      = 0;
  int          n_orph   = 0;
  int          n_warn   = 0;
  localparam logic [29:0] f_d = 30'h2b4d_17e9;
  localparam logic [29:0] r_d = 30'h1c6a_3f52;
  always #2 ref_clk_i = ~ref_clk_i;
  ddrcap_src i_src (.clk_o(clks), .bus_o(bus));
  ddrcap_top i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .tx_clk_shared_i(clks[0]),
    .tx_clk_pair_cd_i(clks[1]), .tx_clk_pair_ef_i(clks[2]), .tx_clk_pair_gh_i(clks[3]),
    .tx_bus_pair_cd_i(bus[9:0]), .tx_bus_pair_ef_i(bus[19:10]), .tx_bus_pair_gh_i(bus[29:20]),
    .mode_independent_i(m_ind), .mode_nibble_i(m_nib), .encoder_sel_i(m_code),
    .chan_c_word_o(word[9:0]), .chan_c_k_o(kf[0]), .chan_c_valid_o(vld[0]),
    .chan_d_word_o(word[19:10]), .chan_d_k_o(kf[1]), .chan_d_valid_o(vld[1]),
    .chan_e_word_o(word[29:20]), .chan_e_k_o(kf[2]), .chan_e_valid_o(vld[2]),
    .chan_f_word_o(word[39:30]), .chan_f_k_o(kf[3]), .chan_f_valid_o(vld[3]),
    .chan_g_word_o(word[49:40]), .chan_g_k_o(kf[4]), .chan_g_valid_o(vld[4]),
    .chan_h_word_o(word[59:50]), .chan_h_k_o(kf[5]), .chan_h_valid_o(vld[5]),
    .orphan_o(orph), .line9_warn_o(warn), .clk_active_o(act), .cfg_o(cfg));
  task automatic summarize();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 6; i++)
      if (vld[i] === 1'b1)
        got[i].push_back({kf[i], word[i*10 +: 10]});
    n_orph <= n_orph + $countones(orph);
    n_warn <= n_warn + $countones(warn);
    if (cyc == 2000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic take(input int ch, input logic [10:0] e);
    chk(got[ch].size() > 0 ? got[ch].pop_front() : 11'hxxx, e);
  endtask
  task automatic none_left();
    for (int i = 0; i < 6; i++)
      chk(11'(got[i].size()), 11'h000);
  endtask
  task automatic mode(input logic i, input logic n, input logic c);
    @(posedge ref_clk_i);
    m_ind <= i;
    m_nib <= n;
    m_code <= c;
    repeat (12) @(posedge ref_clk_i);
    chk({8'h00, cfg}, {8'h00, c, n, i});
  endtask
  task automatic frame(input logic [3:0] m, input logic [29:0] f, input logic [29:0] r);
    i_src.drive_edge(m, 1'b0, f);
    i_src.drive_edge(m, 1'b1, r);
    i_src.release_bus();
    repeat (14) @(posedge ref_clk_i);
  endtask
  task automatic t_mux_plain();
    mode(1'b0, 1'b0, 1'b0);
    frame(4'h1, f_d, r_d);
    chk({8'h00, act}, 11'h007);
    for (int p = 0; p < 3; p++) begin
      take(2*p, {1'b0, f_d[p*10 +: 10]});
      take(2*p+1, {1'b0, r_d[p*10 +: 10]});
    end
    none_left();
  endtask
  task automatic t_mux_code();
    int w;
    mode(1'b0, 1'b0, 1'b1);
    w = n_warn;
    frame(4'h1, f_d, r_d);
    for (int p = 0; p < 3; p++) begin
      take(2*p, {f_d[p*10+8], 2'b00, f_d[p*10 +: 8]});
      take(2*p+1, {r_d[p*10+8], 2'b00, r_d[p*10 +: 8]});
      w = w + f_d[p*10+9] + r_d[p*10+9];
    end
    chk(11'(n_warn), 11'(w));
  endtask
  task automatic t_indep();
    mode(1'b1, 1'b0, 1'b0);
    frame(4'h1, f_d, r_d);
    repeat (70) @(posedge ref_clk_i);
    none_left();
    chk({8'h00, act}, 11'h000);
    frame(4'he, r_d, f_d);
    chk({8'h00, act}, 11'h007);
    for (int p = 0; p < 3; p++) begin
      take(2*p, {1'b0, r_d[p*10 +: 10]});
      take(2*p+1, {1'b0, f_d[p*10 +: 10]});
    end
    none_left();
  endtask
  task automatic t_nib_plain();
    mode(1'b0, 1'b1, 1'b0);
    frame(4'h1, f_d, r_d);
    for (int p = 0; p < 3; p++) begin
      take(2*p, {1'b0, r_d[p*10 +: 5], f_d[p*10 +: 5]});
      take(2*p+1, {1'b0, r_d[p*10+5 +: 5], f_d[p*10+5 +: 5]});
    end
  endtask
  task automatic t_nib_code();
    int q;
    mode(1'b0, 1'b1, 1'b1);
    frame(4'h1, f_d, r_d);
    for (int p = 0; p < 3; p++) begin
      q = p * 10;
      take(2*p, {r_d[q+3], 2'b00, r_d[q+4], r_d[q +: 3], f_d[q+4], f_d[q +: 3]});
      take(2*p+1, {r_d[q+8], 2'b00, r_d[q+9], r_d[q+5 +: 3], f_d[q+9], f_d[q+5 +: 3]});
    end
  endtask
  task automatic t_orphan();
    int o;
    mode(1'b0, 1'b0, 1'b0);
    i_src.drive_edge(4'h1, 1'b0, f_d);
    i_src.release_bus();
    repeat (14) @(posedge ref_clk_i);
    for (int p = 0; p < 3; p++)
      take(2*p, {1'b0, f_d[p*10 +: 10]});
    mode(1'b0, 1'b1, 1'b0);
    o = n_orph;
    i_src.drive_edge(4'h1, 1'b1, r_d);
    i_src.release_bus();
    repeat (14) @(posedge ref_clk_i);
    chk(11'(n_orph - o), 11'h003);
    none_left();
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    i_src.drive_edge(4'hf, 1'b1, r_d);
    i_src.release_bus();
    repeat (14) @(posedge ref_clk_i);
    for (int i = 0; i < 6; i++)
      got[i].delete();
    t_mux_plain();
    t_mux_code();
    t_indep();
    t_nib_plain();
    t_nib_code();
    t_orphan();
    summarize();
  end
endmodule // tb_top
